/* hw/cstc_pkg.sv */
// Package for codec serial transmit control: register map, fields and types
package cstc_pkg;
    // Register byte addresses
    localparam logic [11:0] ADR_PIN_OUT_EN = 12'h2a0;
    localparam logic [11:0] ADR_PIN_IN_EN = 12'h2a4;
    localparam logic [11:0] ADR_SEL_LOW = 12'h2a8;
    localparam logic [11:0] ADR_SEL_HIGH = 12'h2ac;
    localparam logic [11:0] ADR_PIN_VAL = 12'h2b0;
    localparam logic [11:0] ADR_PIN_IN = 12'h2b4;
    localparam logic [11:0] ADR_TX_CTRL = 12'h2c0;
    localparam logic [11:0] ADR_TX_DATA = 12'h2c4;
    localparam logic [11:0] ADR_PAD = 12'h2c8;
    // Control field positions
    localparam int C_EN = 0;
    localparam int C_RUN = 1;
    localparam int C_FIFO = 2;
    localparam int C_DMA = 3;
    localparam int C_BUF1 = 4;
    localparam int C_BUF2 = 5;
    localparam int C_WID = 8;
    localparam int C_MONO = 10;
    localparam int C_FMT = 12;
    localparam int C_STAT = 24;
    localparam logic [1:0] WID_16 = 2'h1;
    localparam logic [2:0] FMT_ONE = 3'h0;
    localparam logic [2:0] FMT_TWO = 3'h3;
    localparam logic [2:0] FMT_HALF = 3'h4;
    localparam logic [2:0] FMT_QUAD = 3'h5;
    // Pin positions on the shared port
    localparam int PIN_W = 6;
    localparam int PIN_BCLK = 2;
    localparam int PIN_FRAME_SYNC_PIN = 3;
    localparam int PIN_SERIAL_OUTPUT_PIN = 5;
    // Transmit FIFO and shifter
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_AW = 3;
    localparam int LVL_W = 4;
    localparam int WORD_W = 16;
    localparam int SHIFT_W = 64;
    localparam logic [LVL_W-1:0] DMA_ROOM = 4'h6;
    localparam logic [31:0] RESET_WORD = 32'h0;

    typedef struct packed {
        logic [2:0] fmt;
        logic mono;
        logic [1:0] width;
        logic buf2;
        logic buf1;
        logic dma_en;
        logic fifo_en;
        logic run;
        logic en;
    } cstc_ctrl_t;

    typedef struct packed {
        logic [PIN_W-1:0] obe;
        logic [PIN_W-1:0] ibe;
        logic [PIN_W-1:0] sel0;
        logic [PIN_W-1:0] sel1;
        logic [PIN_W-1:0] val;
    } cstc_pins_t;
endpackage : cstc_pkg

/* hw/cstc_top.sv */
// Codec serial transmit control with shared pin override, Wishbone slave
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
module cstc_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [5:0] pin_i,
    output logic [5:0] pin_o,
    output logic [5:0] pin_oe_o,
    input wire logic dma_ack_i,
    input wire logic [15:0] dma_data_i,
    output logic dma_req_o,
    output logic [1:0] dma_buf_o,
    output logic dma_abort_o
);
    cstc_pkg::cstc_ctrl_t ctrl_reg;
    cstc_pkg::cstc_pins_t pins_reg;
    logic [31:0] pad_reg;
    logic [5:0] pin_meta_reg;
    logic [5:0] pin_sync_reg;
    logic [5:0] pin_in_reg;
    logic bclk_prev_reg;
    logic fs_prev_reg;
    logic [15:0] fifo_mem [cstc_pkg::FIFO_DEPTH];
    logic [2:0] wr_ptr_reg;
    logic [2:0] rd_ptr_reg;
    logic [3:0] level_reg;
    logic [63:0] shift_reg;
    logic [15:0] held_reg;
    logic buf_sel_reg;
    logic wb_req;
    logic [31:0] bm;
    logic [31:0] ctrl_word;
    logic [31:0] ctrl_next;
    logic [31:0] rd_data;
    logic bclk_fall;
    logic fs_fall;
    logic fs_rise;
    logic tx_live;
    logic fifo_pwr;
    logic dma_live;
    logic fifo_full;
    logic push_dma;
    logic push_sw;
    logic push;
    logic [15:0] push_data;
    logic [15:0] w0;
    logic [15:0] w1;
    logic [15:0] second;
    logic mono_eff;
    logic tw16;
    logic load;
    logic [63:0] load_val;
    logic [1:0] pop_cnt;
    logic [5:0] func_out;

    // Word in first slot, sent high bit first, then 32 pad bits, then zeros
    function automatic logic [63:0] pack1(input logic [15:0] w, input logic [31:0] p,
                                          input logic wide);
        pack1 = wide ? {w, p, 16'h0} : {w[7:0], p, 24'h0};
    endfunction : pack1

    function automatic logic [63:0] pack2(input logic [15:0] a, input logic [15:0] b,
                                          input logic [31:0] p, input logic wide);
        pack2 = wide ? {a, b, p} : {a[7:0], b[7:0], p, 16'h0};
    endfunction : pack2

    // Bus decode and byte-lane mask
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // Power and gating terms
    assign tx_live = ctrl_reg.en & ctrl_reg.run;
    assign fifo_pwr = ctrl_reg.fifo_en | ctrl_reg.en | ctrl_reg.dma_en;
    assign dma_live = ctrl_reg.en & ctrl_reg.dma_en & ctrl_reg.run;
    assign fifo_full = (level_reg == 4'(cstc_pkg::FIFO_DEPTH));
    assign tw16 = (ctrl_reg.width == cstc_pkg::WID_16);

    // Control word view; reserved bits stay zero, status only while powered
    always_comb begin
        ctrl_word = cstc_pkg::RESET_WORD;
        ctrl_word[cstc_pkg::C_EN] = ctrl_reg.en;
        ctrl_word[cstc_pkg::C_RUN] = ctrl_reg.run;
        ctrl_word[cstc_pkg::C_FIFO] = ctrl_reg.fifo_en;
        ctrl_word[cstc_pkg::C_DMA] = ctrl_reg.dma_en;
        ctrl_word[cstc_pkg::C_BUF1] = ctrl_reg.buf1;
        ctrl_word[cstc_pkg::C_BUF2] = ctrl_reg.buf2;
        ctrl_word[cstc_pkg::C_WID +: 2] = ctrl_reg.width;
        ctrl_word[cstc_pkg::C_MONO] = ctrl_reg.mono;
        ctrl_word[cstc_pkg::C_FMT +: 3] = ctrl_reg.fmt;
        ctrl_word[cstc_pkg::C_STAT +: 4] = fifo_pwr ? level_reg : 4'h0;
        ctrl_next = (ctrl_word & ~bm) | (wb_dat_i & bm);
    end

    // Read mux; unmapped addresses answer zero
    always_comb begin
        rd_data = cstc_pkg::RESET_WORD;
        unique case (wb_adr_i)
            cstc_pkg::ADR_PIN_OUT_EN: rd_data[5:0] = pins_reg.obe;
            cstc_pkg::ADR_PIN_IN_EN: rd_data[5:0] = pins_reg.ibe;
            cstc_pkg::ADR_SEL_LOW: rd_data[5:0] = pins_reg.sel0;
            cstc_pkg::ADR_SEL_HIGH: rd_data[5:0] = pins_reg.sel1;
            cstc_pkg::ADR_PIN_VAL: rd_data[5:0] = pins_reg.val;
            cstc_pkg::ADR_PIN_IN: rd_data[5:0] = pin_in_reg;
            cstc_pkg::ADR_TX_CTRL: rd_data = ctrl_word;
            cstc_pkg::ADR_PAD: rd_data = pad_reg;
            default: rd_data = cstc_pkg::RESET_WORD;
        endcase
    end

    // Single-cycle acknowledge, data registered with it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= cstc_pkg::RESET_WORD;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rd_data : cstc_pkg::RESET_WORD;
        end
    end

    // Register writes; only bits 5:0 of pin registers exist
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= '0;
            pins_reg <= '0;
            pad_reg <= cstc_pkg::RESET_WORD;
        end else if (wb_req && wb_we_i) begin
            unique case (wb_adr_i)
                cstc_pkg::ADR_PIN_OUT_EN: pins_reg.obe <= wb_sel_i[0] ? wb_dat_i[5:0] : pins_reg.obe;
                cstc_pkg::ADR_PIN_IN_EN: pins_reg.ibe <= wb_sel_i[0] ? wb_dat_i[5:0] : pins_reg.ibe;
                cstc_pkg::ADR_SEL_LOW: pins_reg.sel0 <= wb_sel_i[0] ? wb_dat_i[5:0] : pins_reg.sel0;
                cstc_pkg::ADR_SEL_HIGH: pins_reg.sel1 <= wb_sel_i[0] ? wb_dat_i[5:0] : pins_reg.sel1;
                cstc_pkg::ADR_PIN_VAL: pins_reg.val <= wb_sel_i[0] ? wb_dat_i[5:0] : pins_reg.val;
                cstc_pkg::ADR_PAD: pad_reg <= (pad_reg & ~bm) | (wb_dat_i & bm);
                cstc_pkg::ADR_TX_CTRL: begin
                    ctrl_reg.en <= ctrl_next[cstc_pkg::C_EN];
                    ctrl_reg.run <= ctrl_next[cstc_pkg::C_RUN];
                    ctrl_reg.fifo_en <= ctrl_next[cstc_pkg::C_FIFO];
                    ctrl_reg.dma_en <= ctrl_next[cstc_pkg::C_DMA];
                    ctrl_reg.buf1 <= ctrl_next[cstc_pkg::C_BUF1];
                    ctrl_reg.buf2 <= ctrl_next[cstc_pkg::C_BUF2];
                    ctrl_reg.width <= ctrl_next[cstc_pkg::C_WID +: 2];
                    ctrl_reg.mono <= ctrl_next[cstc_pkg::C_MONO];
                    ctrl_reg.fmt <= ctrl_next[cstc_pkg::C_FMT +: 3];
                end
                default: pad_reg <= pad_reg;
            endcase
        end
    end

    // Two-flop pin synchroniser; only the second stage feeds logic
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_meta_reg <= 6'h00;
            pin_sync_reg <= 6'h00;
        end else begin
            pin_meta_reg <= pin_i;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // Input register shows a pin only while its buffer is enabled
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_in_reg <= 6'h00;
        end else begin
            pin_in_reg <= pin_sync_reg & pins_reg.ibe;
        end
    end

    // Bit clock falling edge drives data; frame sync sampled there too
    assign bclk_fall = bclk_prev_reg & ~pin_sync_reg[cstc_pkg::PIN_BCLK];
    assign fs_fall = bclk_fall & fs_prev_reg & ~pin_sync_reg[cstc_pkg::PIN_FRAME_SYNC_PIN];
    assign fs_rise = bclk_fall & ~fs_prev_reg & pin_sync_reg[cstc_pkg::PIN_FRAME_SYNC_PIN];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bclk_prev_reg <= 1'b0;
            fs_prev_reg <= 1'b1; // Idle level of frame sync, so reset makes no false rise
        end else begin
            bclk_prev_reg <= pin_sync_reg[cstc_pkg::PIN_BCLK];
            if (bclk_fall) begin
                fs_prev_reg <= pin_sync_reg[cstc_pkg::PIN_FRAME_SYNC_PIN];
            end
        end
    end

    // FIFO fill: DMA beats software if both arrive together
    assign push_dma = dma_ack_i & dma_live & fifo_pwr & ~fifo_full;
    assign push_sw = wb_req & wb_we_i & (wb_adr_i == cstc_pkg::ADR_TX_DATA) & fifo_pwr
                     & ~fifo_full & ~push_dma & ctrl_reg.run;
    assign push = push_dma | push_sw;
    assign push_data = push_dma ? dma_data_i : wb_dat_i[15:0];

    // Frame loader: picks words and pop count per format
    always_comb begin
        w0 = (level_reg != 4'h0) ? fifo_mem[rd_ptr_reg] : 16'h0;
        w1 = (level_reg > 4'h1) ? fifo_mem[rd_ptr_reg + 3'h1] : 16'h0;
        mono_eff = ctrl_reg.mono & ((ctrl_reg.fmt == cstc_pkg::FMT_TWO) |
                   (ctrl_reg.fmt == cstc_pkg::FMT_HALF) | (ctrl_reg.fmt == cstc_pkg::FMT_QUAD));
        second = mono_eff ? w0 : w1;
        load = 1'b0;
        pop_cnt = 2'h0;
        load_val = 64'h0;
        if (tx_live && fs_fall) begin
            load = 1'b1;
            if (ctrl_reg.fmt == cstc_pkg::FMT_TWO || ctrl_reg.fmt == cstc_pkg::FMT_QUAD) begin
                load_val = pack2(w0, second, pad_reg, tw16);
                pop_cnt = mono_eff ? 2'h1 : 2'h2;
            end else if (ctrl_reg.fmt == cstc_pkg::FMT_HALF) begin
                load_val = pack1(w0, {pad_reg[31:16], 16'h0}, tw16);
                pop_cnt = 2'h1;
            end else begin
                load_val = pack1(w0, pad_reg, tw16);
                pop_cnt = 2'h1;
            end
        end else if (tx_live && fs_rise && ctrl_reg.fmt == cstc_pkg::FMT_HALF) begin
            load = 1'b1;
            load_val = pack1(mono_eff ? held_reg : w0, {pad_reg[15:0], 16'h0}, tw16);
            pop_cnt = mono_eff ? 2'h0 : 2'h1;
        end
        // Underrun: never pop more than is held
        if ({2'h0, pop_cnt} > level_reg) begin
            pop_cnt = level_reg[1:0];
        end
    end

    // FIFO storage
    always_ff @(posedge clk_i) begin
        if (push) begin
            fifo_mem[wr_ptr_reg] <= push_data;
        end
    end

    // FIFO pointers; transmit reset empties the FIFO
    always_ff @(posedge clk_i) begin
        if (rst_i || !ctrl_reg.run) begin
            wr_ptr_reg <= 3'h0;
            rd_ptr_reg <= 3'h0;
            level_reg <= 4'h0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + 3'(push);
            rd_ptr_reg <= rd_ptr_reg + 3'(pop_cnt);
            level_reg <= level_reg + 4'(push) - 4'(pop_cnt);
        end
    end

    // Shifter runs only while enabled and out of reset
    always_ff @(posedge clk_i) begin
        if (rst_i || !tx_live) begin
            shift_reg <= 64'h0;
            held_reg <= 16'h0;
        end else if (bclk_fall) begin
            shift_reg <= load ? load_val : {shift_reg[62:0], 1'b0};
            if (load && fs_fall) begin
                held_reg <= w0;
            end
        end
    end

    // Functional pin outputs; only serial data is produced here
    always_comb begin
        func_out = 6'h00;
        func_out[cstc_pkg::PIN_SERIAL_OUTPUT_PIN] = shift_reg[cstc_pkg::SHIFT_W-1];
    end

    // Per-pin source select and buffer enable
    for (genvar i = 0; i < cstc_pkg::PIN_W; i++) begin : g_pin
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                pin_o[i] <= 1'b0;
                pin_oe_o[i] <= 1'b0;
            end else begin
                pin_o[i] <= pins_reg.sel0[i] ? 1'b0 :
                            (pins_reg.sel1[i] ? pins_reg.val[i] : func_out[i]);
                pin_oe_o[i] <= pins_reg.obe[i];
            end
        end
    end

    // DMA request and buffer choice; alternates when both enabled
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dma_req_o <= 1'b0;
            dma_buf_o <= 2'h0;
            dma_abort_o <= 1'b0;
            buf_sel_reg <= 1'b0;
        end else begin
            dma_req_o <= dma_live & (ctrl_reg.buf1 | ctrl_reg.buf2) & (level_reg < cstc_pkg::DMA_ROOM);
            dma_abort_o <= ~ctrl_reg.run & ctrl_reg.dma_en;
            if (!dma_live) begin
                buf_sel_reg <= 1'b0;
            end else if (push_dma && ctrl_reg.buf1 && ctrl_reg.buf2) begin
                buf_sel_reg <= ~buf_sel_reg;
            end
            if (!dma_live) begin
                dma_buf_o <= 2'h0;
            end else if (ctrl_reg.buf1 && ctrl_reg.buf2) begin
                dma_buf_o <= buf_sel_reg ? 2'h2 : 2'h1;
            end else begin
                dma_buf_o <= {ctrl_reg.buf2, ctrl_reg.buf1};
            end
        end
    end

    // Checks
    property p_txrst_clear;
        @(posedge clk_i) disable iff (rst_i) !ctrl_reg.run |=> level_reg == 4'h0;
    endproperty
    a_txrst_clear: assert property (p_txrst_clear) else $error("FIFO not cleared in reset");
    property p_tx_off;
        @(posedge clk_i) disable iff (rst_i) !ctrl_reg.en [*2] |=> !pin_o[cstc_pkg::PIN_SERIAL_OUTPUT_PIN]
            || pins_reg.sel1[cstc_pkg::PIN_SERIAL_OUTPUT_PIN] || $past(pins_reg.sel1[cstc_pkg::PIN_SERIAL_OUTPUT_PIN]);
    endproperty
    a_tx_off: assert property (p_tx_off) else $error("Serial data while disabled");
    property p_pin_val;
        @(posedge clk_i) disable iff (rst_i) (!pins_reg.sel0[0] && pins_reg.sel1[0])
            |=> pin_o[0] == $past(pins_reg.val[0]);
    endproperty
    a_pin_val: assert property (p_pin_val) else $error("Pin not driven from value");
    property p_pin_test;
        @(posedge clk_i) disable iff (rst_i) pins_reg.sel0[1] |=> !pin_o[1];
    endproperty
    a_pin_test: assert property (p_pin_test) else $error("Test pin driven");
    property p_in_gate;
        @(posedge clk_i) disable iff (rst_i) ##1 !$past(pins_reg.ibe[4]) |-> !pin_in_reg[4];
    endproperty
    a_in_gate: assert property (p_in_gate) else $error("Input seen with buffer off");
    property p_dma_gate;
        @(posedge clk_i) disable iff (rst_i) ##1 dma_req_o |-> $past(ctrl_reg.en && ctrl_reg.dma_en);
    endproperty
    a_dma_gate: assert property (p_dma_gate) else $error("DMA without enables");
    property p_buf_gate;
        @(posedge clk_i) disable iff (rst_i) dma_buf_o[0] |-> $past(ctrl_reg.buf1 && ctrl_reg.dma_en);
    endproperty
    a_buf_gate: assert property (p_buf_gate) else $error("Buffer one without enable");
    property p_fifo_refuse;
        @(posedge clk_i) disable iff (rst_i) (!fifo_pwr && ctrl_reg.run) |=> level_reg == $past(level_reg);
    endproperty
    a_fifo_refuse: assert property (p_fifo_refuse) else $error("Unpowered FIFO written");
    property p_reserved;
        @(posedge clk_i) disable iff (rst_i) wb_ack_o && $past(wb_adr_i == cstc_pkg::ADR_SEL_HIGH)
            |-> wb_dat_o[31:6] == 26'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("Reserved bits nonzero");
    property p_reset_zero;
        @(posedge clk_i) rst_i |=> ctrl_reg == '0 && pins_reg == '0;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("Control not zero after reset");
    c_frame: cover property (@(posedge clk_i) disable iff (rst_i) tx_live && fs_fall && load);
    c_mono: cover property (@(posedge clk_i) disable iff (rst_i) fs_fall && mono_eff && tx_live);
    c_dma: cover property (@(posedge clk_i) disable iff (rst_i) push_dma);
    c_split: cover property (@(posedge clk_i) disable iff (rst_i) tx_live && fs_rise && load);
endmodule : cstc_top

/* tb/cstc_codec_model.sv */
// Behavioural codec: drives bit clock and frame sync, captures serial data
`timescale 1ns/1ps
module cstc_codec_model (
    input wire logic serial_output_pin_i,
    output logic bclk_o,
    output logic frame_sync_pin_o,
    output logic done_o,
    output logic [63:0] bits_o
);
    // Idle levels; the bit clock stands high between frames
    initial begin
        bclk_o = 1'b1;
        frame_sync_pin_o = 1'b1;
        done_o = 1'b0;
        bits_o = 64'h0;
    end

    // One frame of n bits at a 64 ns bit period; m > 0 raises frame sync after bit m
    task automatic frame(input int n, input int m = 0);
        #32 bclk_o = 1'b0;
        #16 frame_sync_pin_o = 1'b0; // Next fall is the frame start
        #16 bclk_o = 1'b1;
        for (int k = 1; k <= n; k++) begin
            #32 bclk_o = 1'b0;
            #32 bclk_o = 1'b1;
            bits_o = {bits_o[62:0], serial_output_pin_i}; // Half a bit after launch, settled
            if (k == m) begin
                frame_sync_pin_o = 1'b1; // Mid-frame rise for the split format
            end
        end
        frame_sync_pin_o = 1'b1;
        // Trailing clock, so the end-of-frame rise never counts in the next frame
        #32 bclk_o = 1'b0;
        #32 bclk_o = 1'b1;
        done_o = 1'b1;
        #5 done_o = 1'b0;
    endtask : frame
endmodule : cstc_codec_model

/* tb/cstc_top_tb.sv */
// Self-checking bench for the codec transmit control block
`timescale 1ns/1ps
module cstc_top_tb;
    logic clk_i, rst_i, cyc, stb, we, dma_ack, ack, dma_req, dma_abort, bclk, frame_sync_pin, fdone;
    logic [11:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, pad;
    logic [5:0] gp_in, pin_i, pin_o, pin_oe;
    logic [15:0] dma_data;
    logic [1:0] dma_buf;
    logic [63:0] fbits;
    logic [31:0] rdq[$];
    logic [55:0] frq[$];
    int n_errors = 0;
    int tests_run = 0;
    localparam logic [11:0] CTL = 12'h2c0;
    localparam logic [11:0] FIFO = 12'h2c4;

    // Bit clock and frame sync come from the codec, the rest from the bench
    assign pin_i = {gp_in[5:4], frame_sync_pin, bclk, gp_in[1:0]};

    cstc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe), .dma_ack_i(dma_ack),
        .dma_data_i(dma_data), .dma_req_o(dma_req), .dma_buf_o(dma_buf),
        .dma_abort_o(dma_abort));
    cstc_codec_model codec (.serial_output_pin_i(pin_o[5]), .bclk_o(bclk), .frame_sync_pin_o(frame_sync_pin), .done_o(fdone),
        .bits_o(fbits));

    // 200 MHz system clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic report_and_stop();
        if (n_errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop

    // Classic single cycle; waits for ack under a bound, then releases
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            n_errors++;
            report_and_stop();
        end
    endtask : bus

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        rdq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd

    task automatic xfer(input logic [55:0] e, input int m = 0);
        frq.push_back(e);
        codec.frame(56, m);
    endtask : xfer

    // DMA beats of one cycle each, one idle cycle between
    task automatic feed(input int n);
        repeat (n) begin
            @(posedge clk_i);
            dma_ack <= 1'b1;
            dma_data <= 16'($urandom);
            @(posedge clk_i);
            dma_ack <= 1'b0;
        end
        repeat (3) @(posedge clk_i);
    endtask : feed

    task automatic settle();
        repeat (3) @(posedge clk_i);
        #1;
    endtask : settle

    // Oldest note against each read answer
    always @(posedge clk_i) begin
        if (ack === 1'b1 && cyc === 1'b1 && we === 1'b0)
            check("read", 64'(rdat), 64'(rdq.pop_front()));
    end

    // Oldest note against each captured frame
    always @(posedge fdone) check("frame", 64'(fbits[55:0]), 64'(frq.pop_front()));

    // Main sequence
    initial begin
        logic [11:0] regs[9];
        logic [31:0] a, b, v;
        int i;
        regs = '{12'h2a0, 12'h2a4, 12'h2a8, 12'h2ac, 12'h2b0, 12'h2b4, CTL, 12'h2c8, 12'h2bc};
        {cyc, stb, we, dma_ack} = 4'h0;
        adr = 12'h0;
        sel = 4'hf;
        wdat = 32'h0;
        dma_data = 16'h0;
        gp_in = 6'h0;
        rst_i = 1'b1;
        void'($urandom(32'h509f102d));
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        settle();
        check("outs", 64'({pin_o, pin_oe, dma_req, dma_buf, dma_abort}), 64'h0);
        foreach (regs[i]) rd(regs[i], 32'h0);
        for (i = 0; i < 6; i++) begin
            wr(regs[i], 32'hffffffff);
            rd(regs[i], (i < 5) ? 32'h3f : 32'h0);
            wr(regs[i], 32'h0);
        end
        wr(CTL, 32'hfffffffd);
        rd(CTL, 32'h0000773d);
        wr(CTL, 32'h0);
        // Pin override: select-high picks the value bit, select-low forces test use
        repeat (4) begin
            a = $urandom;
            v = $urandom;
            b = $urandom;
            wr(12'h2a0, v);
            wr(12'h2ac, b);
            wr(12'h2b0, a);
            settle();
            check("pin_o", 64'(pin_o), 64'(b[5:0] & a[5:0]));
            check("pin_oe", 64'(pin_oe), 64'(v[5:0]));
            wr(12'h2a8, 32'h3f);
            settle();
            check("pin_test", 64'(pin_o), 64'h0);
            wr(12'h2a8, 32'h0);
        end
        wr(12'h2ac, 32'h0);
        repeat (3) begin
            v = $urandom;
            b = $urandom;
            gp_in <= v[5:0];
            wr(12'h2a4, b);
            settle();
            rd(12'h2b4, 32'({v[5:4], 2'b11, v[1:0]} & b[5:0]));
        end
        pad = $urandom;
        wr(12'h2c8, pad);
        rd(12'h2c8, pad);
        // Width codes, format zero; enable set while run held low
        for (i = 0; i < 4; i++) begin
            a = $urandom;
            wr(CTL, 32'h5 | 32'(i << 8));
            wr(CTL, 32'h7 | 32'(i << 8));
            wr(FIFO, a);
            rd(CTL, 32'h01000007 | 32'(i << 8));
            if (i == 1) xfer({a[15:0], pad, 8'h0});
            else xfer({a[7:0], pad, 16'h0});
        end
        wr(CTL, 32'h2);
        wr(FIFO, 32'h1234);
        wr(CTL, 32'h6);
        rd(CTL, 32'h6);
        wr(FIFO, 32'hff);
        rd(CTL, 32'h01000006);
        xfer(56'h0);
        // Two-slot formats, stereo and mono; then mono bit ignored in format zero
        a = $urandom;
        b = $urandom;
        wr(CTL, 32'h3005);
        wr(CTL, 32'h3007);
        wr(FIFO, a);
        wr(FIFO, b);
        xfer({a[7:0], b[7:0], pad, 8'h0});
        rd(CTL, 32'h3007);
        for (i = 3; i < 6; i += 2) begin
            wr(CTL, 32'h0407 | 32'(i << 12));
            wr(FIFO, a);
            xfer({a[7:0], a[7:0], pad, 8'h0});
        end
        wr(CTL, 32'h0407);
        wr(FIFO, a);
        wr(FIFO, b);
        xfer({a[7:0], pad, 16'h0});
        rd(CTL, 32'h01000407);
        wr(CTL, 32'h0405);
        rd(CTL, 32'h0405);
        // Split format: second word at the mid-frame rise, a copy of the first in mono
        for (i = 0; i < 2; i++) begin
            wr(CTL, 32'h4005 | 32'(i << 10));
            wr(CTL, 32'h4007 | 32'(i << 10));
            wr(FIFO, a);
            wr(FIFO, b);
            xfer({a[7:0], pad[31:16], ((i == 1) ? a[7:0] : b[7:0]), pad[15:0], 8'h0},
                 24);
        end
        // DMA gating, buffer choice and abort
        wr(CTL, 32'h1a);
        settle();
        check("dma_off", 64'({dma_req, dma_buf}), 64'h0);
        wr(CTL, 32'h19);
        wr(CTL, 32'h1b);
        settle();
        check("dma_b1", 64'({dma_req, dma_buf}), 64'h5);
        feed(1);
        a = 32'(dma_data);
        feed(5);
        check("dma_full", 64'(dma_req), 64'h0);
        rd(CTL, 32'h0600001b);
        xfer({a[7:0], pad, 16'h0});
        wr(CTL, 32'h19);
        settle();
        check("abort", 64'(dma_abort), 64'h1);
        rd(CTL, 32'h19);
        wr(CTL, 32'h29);
        wr(CTL, 32'h2b);
        settle();
        check("dma_b2", 64'({dma_req, dma_buf}), 64'h6);
        wr(CTL, 32'h3b);
        settle();
        v = 32'(dma_buf);
        feed(1);
        check("dma_alt", 64'(dma_buf), 64'({v[0], v[1]}));
        report_and_stop();
    end
endmodule : cstc_top_tb
